/* File: hdl/rh_status_regs.vh */
// constants for the root hub descriptor and status register bank
`ifndef RH_STATUS_REGS_VH
`define RH_STATUS_REGS_VH
`define OFS_PORT_DESC      8'h4C
`define OFS_STATUS_CMD     8'h50
`define OFS_IRQ_STATUS     8'h54
`define OFS_IRQ_MASK       8'h58
`define OFS_CONTROL        8'h5C
`define BIT_MASK_PORT2     18
`define BIT_MASK_PORT1     17
`define BIT_REM_PORT2      2
`define BIT_REM_PORT1      1
`define BIT_WAKE_CLR       31
`define BIT_OC_CHANGE      17
`define BIT_PWR_SET        16
`define BIT_WAKE_SET       15
`define BIT_OC_IND         1
`define BIT_PWR_CLR        0
`define BIT_CTL_PSM        0
`define BIT_CTL_GANGED_OC  1
`define RST_PORT_MASK      2'h0
`define RST_OC_CHANGE      1'h1
`define RST_CTL_PSM        1'h0
`define RST_CTL_GANGED_OC  1'h1
`define IRQ_BIT_OC         0
`define IRQ_BIT_REM        1
`endif

/* File: hdl/usb_root_hub_desc_status_regs.v */
// root hub port descriptor and hub status/command registers, AXI4-Lite slave
// Summary of operation
// - descriptor bit 18 masks port 2 power control when one
// - descriptor bit 17 masks port 1 power control when one
// - descriptor bits 31:19 read one; software writes one
// - power mask field restored only by hardware reset
// - descriptor bit 2 reports device connected on port 2
// - descriptor bit 1 reports device connected on port 1
// - descriptor bit 16 and other low bits read zero
// - writing one to status bit 31 clears remote wakeup enable
// - overcurrent change flag sets when overcurrent indicator changes
// - writing one clears overcurrent change flag, zero keeps it
// - wakeup, change, power bits reset only by hardware reset
// - bits 16, 15, 0 are commands on write; bits 15, 0 read status, bit 16 reads zero
// - power set command powers all ports or unmasked ports only
// - power clear command unpowers all ports or unmasked ports only
// - writing one to bit 15 sets remote wakeup enable
// - overcurrent indicator reads one during ganged overcurrent
`timescale 1ns/1ps
`default_nettype none
`include "rh_status_regs.vh"
module usb_root_hub_desc_status_regs (
   input  wire        MCLK,
   input  wire        SYS_RST,
   input  wire        SOFT_RST,
   input  wire [1:0]  PORT_CONNECTED,
   input  wire        OVERCURRENT_IN,
   input  wire        LOCAL_POWER_IN,
   input  wire        DEVICE_WAKE_IN,
   input  wire [31:0] S_AXI_AWADDR,
   input  wire        S_AXI_AWVALID,
   output reg         S_AXI_AWREADY,
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   input  wire        S_AXI_WVALID,
   output reg         S_AXI_WREADY,
   output reg  [1:0]  S_AXI_BRESP,
   output reg         S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   input  wire [31:0] S_AXI_ARADDR,
   input  wire        S_AXI_ARVALID,
   output reg         S_AXI_ARREADY,
   output reg  [31:0] S_AXI_RDATA,
   output reg  [1:0]  S_AXI_RRESP,
   output reg         S_AXI_RVALID,
   input  wire        S_AXI_RREADY,
   output reg  [1:0]  PORT_POWER,
   output reg         REMOTE_WAKEUP_ENABLE,
   output reg         IRQ
);

////////////////////////////////////////////////////////////////////////////////
// state
reg  [1:0]  port_power_mask;
reg  [1:0]  port_removable;
reg  [1:0]  port_removable_prev;
reg         overcurrent_indicator;
reg         overcurrent_prev;
reg         overcurrent_change_flag;
reg         power_switch_mode;
reg         ganged_oc_mode;
reg  [1:0]  irq_status;
reg  [1:0]  irq_mask;
reg  [7:0]  aw_addr;
reg         aw_held;
reg  [31:0] w_data;
reg  [3:0]  w_strb;
reg         w_held;
wire        oc_event;
wire [1:0]  rem_event;
wire        do_write;
wire [31:0] wmask;
wire [31:0] wbits;
wire        sel_desc;
wire        sel_status;
wire        sel_irq_st;
wire        sel_irq_mk;
wire        sel_ctrl;
wire        pwr_set;
wire        pwr_clr;
wire [1:0]  irq_set;
wire [1:0]  irq_clear;
wire [1:0]  next_irq_status;
wire [1:0]  port_locked;
wire [1:0]  next_power;
genvar      gi;

function [31:0] lane_mask;
   input [3:0] strb;
   lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
endfunction

function hit;
   input [7:0] a;
   input [7:0] ofs;
   hit = (a == ofs);
endfunction

assign do_write  = aw_held && w_held && !S_AXI_BVALID;
assign wmask     = lane_mask(w_strb);
assign wbits     = w_data & wmask;
assign oc_event  = overcurrent_indicator != overcurrent_prev;
assign rem_event = port_removable ^ port_removable_prev;

////////////////////////////////////////////////////////////////////////////////
// write decode, one strobe per register
assign sel_desc        = do_write && hit(aw_addr, `OFS_PORT_DESC);
assign sel_status      = do_write && hit(aw_addr, `OFS_STATUS_CMD);
assign sel_irq_st      = do_write && hit(aw_addr, `OFS_IRQ_STATUS);
assign sel_irq_mk      = do_write && hit(aw_addr, `OFS_IRQ_MASK);
assign sel_ctrl        = do_write && hit(aw_addr, `OFS_CONTROL);
assign pwr_set         = sel_status && wbits[`BIT_PWR_SET];
assign pwr_clr         = sel_status && wbits[`BIT_PWR_CLR];
assign irq_set         = {|rem_event, oc_event};
assign irq_clear       = sel_irq_st ? wbits[1:0] : 2'h0;
assign next_irq_status = (irq_status & ~irq_clear) | irq_set;

////////////////////////////////////////////////////////////////////////////////
// write channel
always @(posedge MCLK or posedge SYS_RST) begin
   if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= 2'h0;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
   end else begin
      S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY  <= !w_held && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_held <= 1'b1;
         aw_addr <= S_AXI_AWADDR[7:0];
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_held <= 1'b1;
         w_data <= S_AXI_WDATA;
         w_strb <= S_AXI_WSTRB;
      end
      if (do_write) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         S_AXI_BVALID <= 1'b1;
         if (hit(aw_addr, `OFS_PORT_DESC) || hit(aw_addr, `OFS_STATUS_CMD) ||
             hit(aw_addr, `OFS_IRQ_STATUS) || hit(aw_addr, `OFS_IRQ_MASK) ||
             hit(aw_addr, `OFS_CONTROL))
            S_AXI_BRESP <= 2'h0;
         else
            S_AXI_BRESP <= 2'h2;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// descriptor power mask; no soft reset reaches it
always @(posedge MCLK or posedge SYS_RST) begin
   if (SYS_RST) begin
      port_power_mask <= `RST_PORT_MASK;
   end else if (sel_desc && w_strb[2]) begin
      port_power_mask[1] <= w_data[`BIT_MASK_PORT2];
      port_power_mask[0] <= w_data[`BIT_MASK_PORT1];
   end
end

////////////////////////////////////////////////////////////////////////////////
// overcurrent indicator and its previous value
always @(posedge MCLK or posedge SYS_RST) begin
   if (SYS_RST) begin
      overcurrent_indicator <= 1'b0;
      overcurrent_prev      <= 1'b0;
   end else begin
      overcurrent_indicator <= ganged_oc_mode & OVERCURRENT_IN;
      overcurrent_prev      <= overcurrent_indicator;
   end
end

////////////////////////////////////////////////////////////////////////////////
// device presence and its previous value
always @(posedge MCLK or posedge SYS_RST) begin
   if (SYS_RST) begin
      port_removable      <= 2'h0;
      port_removable_prev <= 2'h0;
   end else begin
      port_removable      <= PORT_CONNECTED;
      port_removable_prev <= port_removable;
   end
end

////////////////////////////////////////////////////////////////////////////////
// remote wakeup enable; clear wins over set
always @(posedge MCLK or posedge SYS_RST) begin
   if (SYS_RST) begin
      REMOTE_WAKEUP_ENABLE <= 1'b0;
   end else if (sel_status && wbits[`BIT_WAKE_CLR]) begin
      REMOTE_WAKEUP_ENABLE <= 1'b0;
   end else if (sel_status && wbits[`BIT_WAKE_SET]) begin
      REMOTE_WAKEUP_ENABLE <= 1'b1;
   end
end

////////////////////////////////////////////////////////////////////////////////
// global power commands, one slice per port; set wins over clear
generate
   for (gi = 0; gi < 2; gi = gi + 1) begin : g_port
      // a masked port in per-port mode ignores both commands
      assign port_locked[gi] = power_switch_mode & port_power_mask[gi];
      assign next_power[gi]  = port_locked[gi] ? PORT_POWER[gi] :
                               pwr_set         ? 1'b1 :
                               pwr_clr         ? 1'b0 : PORT_POWER[gi];
   end
endgenerate

always @(posedge MCLK or posedge SYS_RST) begin
   if (SYS_RST)
      PORT_POWER <= 2'h0;
   else
      PORT_POWER <= next_power;
end

////////////////////////////////////////////////////////////////////////////////
// overcurrent change flag; a change in the clear cycle wins
always @(posedge MCLK or posedge SYS_RST) begin
   if (SYS_RST) begin
      overcurrent_change_flag <= `RST_OC_CHANGE;
   end else if (oc_event) begin
      overcurrent_change_flag <= 1'b1;
   end else if (sel_status && wbits[`BIT_OC_CHANGE]) begin
      overcurrent_change_flag <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// power switching and overcurrent reporting modes
always @(posedge MCLK or posedge SYS_RST) begin
   if (SYS_RST) begin
      power_switch_mode <= `RST_CTL_PSM;
      ganged_oc_mode    <= `RST_CTL_GANGED_OC;
   end else if (sel_ctrl && w_strb[0]) begin
      power_switch_mode <= w_data[`BIT_CTL_PSM];
      ganged_oc_mode    <= w_data[`BIT_CTL_GANGED_OC];
   end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt status, mask and output; soft reset empties the status
always @(posedge MCLK or posedge SYS_RST) begin
   if (SYS_RST) begin
      irq_status <= 2'h0;
      irq_mask   <= 2'h0;
      IRQ        <= 1'b0;
   end else begin
      if (sel_irq_mk && w_strb[0])
         irq_mask <= w_data[1:0];
      if (SOFT_RST)
         irq_status <= 2'h0;
      else
         irq_status <= next_irq_status;
      IRQ <= |(irq_status & irq_mask);
   end
end

////////////////////////////////////////////////////////////////////////////////
// read channel
always @(posedge MCLK or posedge SYS_RST) begin
   if (SYS_RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= 2'h0;
   end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP  <= 2'h0;
         case (S_AXI_ARADDR[7:0])
            `OFS_PORT_DESC:
               // upper reserved ones, bit 16 and low spare bits zero
               S_AXI_RDATA <= {13'h1FFF, port_power_mask, 1'b0,
                               13'h0000, port_removable, 1'b0};
            `OFS_STATUS_CMD:
               S_AXI_RDATA <= {14'h0000, overcurrent_change_flag, 1'b0,
                               DEVICE_WAKE_IN, 13'h0000,
                               overcurrent_indicator, LOCAL_POWER_IN};
            `OFS_IRQ_STATUS:
               S_AXI_RDATA <= {30'h00000000, irq_status};
            `OFS_IRQ_MASK:
               S_AXI_RDATA <= {30'h00000000, irq_mask};
            `OFS_CONTROL:
               S_AXI_RDATA <= {30'h00000000, ganged_oc_mode, power_switch_mode};
            default: begin
               S_AXI_RDATA <= 32'h00000000;
               S_AXI_RRESP <= 2'h2;
            end
         endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end
end

endmodule
`default_nettype wire

/* File: bench/usb_root_hub_desc_status_regs_properties.sv */
// assertion checker for the root hub descriptor and status register bank
`timescale 1ns/1ps
`default_nettype none
`include "rh_status_regs.vh"
module rh_regs_checker (
   input wire logic        MCLK,
   input wire logic        SYS_RST,
   input wire logic [1:0]  PORT_CONNECTED,
   input wire logic        S_AXI_BVALID,
   input wire logic [31:0] S_AXI_ARADDR,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0]  S_AXI_RRESP,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY,
   input wire logic [1:0]  PORT_POWER,
   input wire logic        REMOTE_WAKEUP_ENABLE
);
   logic [7:0] ofs;
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) ofs <= 8'h00;
      else if (S_AXI_ARVALID && S_AXI_ARREADY) ofs <= S_AXI_ARADDR[7:0];
   end
   wire logic rd_desc = ofs == `OFS_PORT_DESC;
   wire logic rd_bad  = ofs < `OFS_PORT_DESC || ofs > `OFS_CONTROL || ofs[1:0] != 2'h0;
   default clocking @(posedge MCLK); endclocking
   default disable iff (SYS_RST);
   property p_ones; S_AXI_RVALID && rd_desc |-> S_AXI_RDATA[31:19] == 13'h1FFF; endproperty
   a_ones: assert property (p_ones) else $error("descriptor top bits not one");
   property p_zeros; S_AXI_RVALID && rd_desc |-> {S_AXI_RDATA[16:3], S_AXI_RDATA[0]} == 15'h0; endproperty
   a_zeros: assert property (p_zeros) else $error("descriptor reserved bits not zero");
   property p_rem; $rose(S_AXI_RVALID) && rd_desc && $past(PORT_CONNECTED, 3) == PORT_CONNECTED
      |-> S_AXI_RDATA[2:1] == PORT_CONNECTED; endproperty
   a_rem: assert property (p_rem) else $error("removable bits wrong");
   property p_wake; $changed(REMOTE_WAKEUP_ENABLE) |-> $rose(S_AXI_BVALID); endproperty
   a_wake: assert property (p_wake) else $error("wakeup enable moved without a write");
   property p_pwr; $changed(PORT_POWER) |-> $rose(S_AXI_BVALID); endproperty
   a_pwr: assert property (p_pwr) else $error("port power moved without a write");
   property p_bad; S_AXI_RVALID && rd_bad |-> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0; endproperty
   a_bad: assert property (p_bad) else $error("unmapped read not refused");
   property p_ar; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
   a_ar: assert property (p_ar) else $error("read answer late");
   property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
endmodule
bind usb_root_hub_desc_status_regs rh_regs_checker u_chk (.MCLK, .SYS_RST, .PORT_CONNECTED,
   .S_AXI_BVALID, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
   .S_AXI_RVALID, .S_AXI_RREADY, .PORT_POWER, .REMOTE_WAKEUP_ENABLE);
`default_nettype wire

/* File: bench/tb_usb_root_hub_desc_status_regs.sv */
// self-checking bench for the root hub register bank
`timescale 1ns/1ps
`default_nettype none
module tb_usb_root_hub_desc_status_regs;
   logic        MCLK = 1'h0, SYS_RST = 1'h1, SOFT_RST = 1'h0, OVERCURRENT_IN = 1'h0;
   logic        LOCAL_POWER_IN = 1'h1, DEVICE_WAKE_IN = 1'h1;
   logic [1:0]  PORT_CONNECTED = 2'h2;
   logic [31:0] S_AXI_AWADDR = 32'h0, S_AXI_WDATA = 32'h0, S_AXI_ARADDR = 32'h0, d;
   logic [3:0]  S_AXI_WSTRB = 4'hF;
   logic        S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
   logic        S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
   logic [1:0]  r;
   wire logic   S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   wire logic   REMOTE_WAKEUP_ENABLE, IRQ;
   wire logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, PORT_POWER;
   wire logic [31:0] S_AXI_RDATA;
   int          num_errors = 0, n_tests = 0;
   usb_root_hub_desc_status_regs DUT (.MCLK, .SYS_RST, .SOFT_RST, .PORT_CONNECTED, .OVERCURRENT_IN,
      .LOCAL_POWER_IN, .DEVICE_WAKE_IN, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
      .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
      .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
      .S_AXI_RREADY, .PORT_POWER, .REMOTE_WAKEUP_ENABLE, .IRQ);
   initial forever #2.5 MCLK = ~MCLK;
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge MCLK);
      S_AXI_AWADDR <= {24'h0, a};
      S_AXI_WDATA <= v;
      S_AXI_AWVALID <= 1'h1;
      S_AXI_WVALID <= 1'h1;
      S_AXI_BREADY <= 1'h1;
      forever begin
         @(posedge MCLK);
         if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
         if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
         if (S_AXI_BVALID && S_AXI_BREADY) begin
            r = S_AXI_BRESP;
            S_AXI_BREADY <= 1'h0;
            break;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, input int lag = 0);
      int n;
      n = 0;
      @(posedge MCLK);
      S_AXI_ARADDR <= {24'h0, a};
      S_AXI_ARVALID <= 1'h1;
      S_AXI_RREADY <= (lag == 0);
      forever begin
         @(posedge MCLK);
         n++;
         if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
         if (S_AXI_RVALID && S_AXI_RREADY) begin
            d = S_AXI_RDATA;
            r = S_AXI_RRESP;
            S_AXI_RREADY <= 1'h0;
            break;
         end
         if (n == lag) S_AXI_RREADY <= 1'h1;
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a);
      chk(d & m, e);
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      #20000;
      num_errors++;
      summarize;
   end
   initial begin
      repeat (20) @(posedge MCLK);
      SYS_RST <= 1'h0;
      rc(8'h4C, 32'hFFFFFFFF, 32'hFFF80004);
      wr(8'h4C, 32'hFFFE0000);
      chk(32'(r), 32'h0);
      rc(8'h4C, 32'hFFFFFFFF, 32'hFFFE0004);
      SOFT_RST <= 1'h1;
      @(posedge MCLK);
      SOFT_RST <= 1'h0;
      PORT_CONNECTED <= 2'h1;
      rc(8'h4C, 32'hFFFFFFFF, 32'hFFFE0002);
      rc(8'h50, 32'h00028003, 32'h00028001);
      wr(8'h50, 32'h00020000);
      rc(8'h50, 32'h00028003, 32'h00008001);
      OVERCURRENT_IN <= 1'h1;
      repeat (2) @(posedge MCLK);
      rc(8'h50, 32'h00028003, 32'h00028003);
      wr(8'h50, 32'h00020000);
      OVERCURRENT_IN <= 1'h0;
      repeat (2) @(posedge MCLK);
      rc(8'h50, 32'h00028003, 32'h00028001);
      wr(8'h50, 32'h00000000);
      rc(8'h50, 32'h00020000, 32'h00020000);
      wr(8'h50, 32'h00008000);
      chk(32'(REMOTE_WAKEUP_ENABLE), 32'h1);
      wr(8'h50, 32'h80008000);
      chk(32'(REMOTE_WAKEUP_ENABLE), 32'h0);
      wr(8'h5C, 32'h00000002);
      wr(8'h50, 32'h00010000);
      chk(32'(PORT_POWER), 32'h3);
      wr(8'h50, 32'h00000001);
      chk(32'(PORT_POWER), 32'h0);
      wr(8'h5C, 32'h00000003);
      wr(8'h4C, 32'hFFFC0000);
      wr(8'h50, 32'h00010000);
      chk(32'(PORT_POWER), 32'h1);
      wr(8'h4C, 32'hFFFA0000);
      wr(8'h50, 32'h00010000);
      chk(32'(PORT_POWER), 32'h3);
      wr(8'h50, 32'h00000001);
      chk(32'(PORT_POWER), 32'h1);
      rc(8'h54, 32'h00000001, 32'h00000001);
      chk(32'(IRQ), 32'h0);
      wr(8'h58, 32'h00000001);
      repeat (2) @(posedge MCLK);
      chk(32'(IRQ), 32'h1);
      wr(8'h54, 32'h00000001);
      repeat (2) @(posedge MCLK);
      chk(32'(IRQ), 32'h0);
      rd(8'h60);
      chk({r, d[29:0]}, 32'h80000000);
      wr(8'h60, 32'hFFFFFFFF);
      chk(32'(r), 32'h2);
      rd(8'h58, 4);
      chk(d, 32'h00000001);
      SYS_RST <= 1'h1;
      repeat (3) @(posedge MCLK);
      SYS_RST <= 1'h0;
      chk(32'(PORT_POWER), 32'h0);
      rc(8'h4C, 32'hFFFFFFFF, 32'hFFF80002);
      rc(8'h50, 32'h00028003, 32'h00028001);
      summarize;
   end
endmodule
`default_nettype wire
